// *** hw/tmtc_status_cfg.svh ***
// Register map, field positions, reset values and widths of the TM/TC status block
//
// Notes on behaviour
// R1: Downlink buffer-fault flag reads 1 after a transmit FIFO error, else 0.
// R2: Downlink transfer-active flag reads 1 while a transfer runs.
// R3: Downlink status shows descriptor address LSB of last DMA-finished event.
// R4: Downlink CRC fault counter is eight bits and wraps to zero.
// R5: Uplink received-frame counter is eight bits, wraps after 255.
// R6: Uplink status shows byte length of buffer being read, at most 1024.
// R7: Twelve-bit vector shows which pulse lines the last command activated.
// R8: Accepted pulse command counter wraps after 15.
// R9: Lost-frame counter for full buffers, eight bits, wraps after 255.
// R10: Rejected pulse command counter, eight bits, wraps after 255.
// R11: Rejected telecommand counter, eight bits, wraps after 255.
// R12: Uplink CRC fault counter, eight bits, wraps after 255.
// R13: Writing 1 to frame control bit 1 signals frame read; 0 ignored.
// R14: Writing 1 to frame control bit 0 resets buffer function; others ignored.
// R15: Timestamp period 0 disables; N captures on every Nth sent frame.
// R16: Telemetry is sent only while downlink enabled; otherwise submissions fail.
// R17: Host aborts a telemetry wait after 1500 ms.
// R18: Host submits transfer lengths from 0 to 65535 bytes.
// R19: Link control word is host writable and reads back.
// R20: Link control word inserted into frames only while insertion enabled.
// R21: Reset clears flags and counters; frame control register reads zero.
`ifndef TMTC_STATUS_CFG_SVH
`define TMTC_STATUS_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_DL_CTRL 12'h000
`define OFS_DL_STATUS 12'h004
`define OFS_DL_ERRCNT 12'h008
`define OFS_UL_STATUS 12'h00c
`define OFS_UL_ERRCNT 12'h010
`define OFS_FRAME_CTRL 12'h014
`define OFS_LINK_WORD 12'h018
`define OFS_TS_PERIOD 12'h01c
`define OFS_TS_COUNT 12'h020

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_DL_ENABLE 0
`define BIT_OCF_ENABLE 1
`define BIT_FC_RESET 0
`define BIT_FC_READ 1
`define BIT_DL_FAULT 8
`define BIT_DL_ACTIVE 9
`define BIT_DL_REFUSED 10

// ------------------------------------------------------------
// Widths and limits
// ------------------------------------------------------------
`define LEN_MAX 11'h400
`define CNT8_ONE 8'h01
`define CNT4_ONE 4'h1
`define TS_OFF 8'h00
`define ZERO32 32'h0000_0000

`endif

// *** hw/tmtc_status_pkg.sv ***
// Types of the TM/TC status block
package tmtc_status_pkg;
   typedef enum logic [1:0] {
      DL_IDLE = 2'b00,
      DL_SEND = 2'b01,
      DL_FAULT = 2'b10
   } dl_state_t;
endpackage

// *** hw/wrap_counter.sv ***
// Wrapping event counter with synchronous clear
`timescale 1ns/1ps
`include "tmtc_status_cfg.svh"
module wrap_counter #(
   parameter int WIDTH = 8
) (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Async reset, high
   input wire logic clear, // Synchronous clear
   input wire logic inc, // Count one event
   output logic [WIDTH-1:0] count // Current count
);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (inc) begin
         count <= count + WIDTH'(1);
      end
   end
endmodule

// *** hw/tmtc_status_ctrl.sv ***
// APB register block with TM/TC status, error counters and control
`timescale 1ns/1ps
`include "tmtc_status_cfg.svh"
module tmtc_status_ctrl (
   input wire logic clk, // 10 MHz clock
   input wire logic sys_rst, // Async reset, high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic txStart, // Telemetry submission pulse
   input wire logic txFrameSent, // One frame sent pulse
   input wire logic txDone, // DMA finished pulse
   input wire logic [7:0] txDescAddr, // Descriptor address LSB
   input wire logic txFifoError, // Transmit FIFO error pulse
   input wire logic txCrcError, // Downlink CRC error pulse
   input wire logic rxFrame, // Uplink frame received pulse
   input wire logic [10:0] rxLength, // Length of buffer being read
   input wire logic rxOverflow, // Frame lost, buffers full
   input wire logic rxRejected, // Telecommand rejected pulse
   input wire logic rxCrcError, // Uplink CRC error pulse
   input wire logic pulseAccept, // Pulse command accepted
   input wire logic pulseReject, // Pulse command rejected
   input wire logic [11:0] pulseLines, // Lines of accepted command
   output logic txGo, // Downlink may send
   output logic ocfInsert, // Insert link word into frames
   output logic [31:0] linkWord, // Stored link control word
   output logic timestampTake, // Capture timestamp pulse
   output logic rxBufferReset, // Buffer function reset pulse
   output logic rxFrameRead // Frame consumed pulse
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic wrEn;
   logic rdEn;
   logic known;
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !penable && !pwrite;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   assign known = hit(paddr, `OFS_DL_CTRL) || hit(paddr, `OFS_DL_STATUS) ||
                  hit(paddr, `OFS_DL_ERRCNT) || hit(paddr, `OFS_UL_STATUS) ||
                  hit(paddr, `OFS_UL_ERRCNT) || hit(paddr, `OFS_FRAME_CTRL) ||
                  hit(paddr, `OFS_LINK_WORD) || hit(paddr, `OFS_TS_PERIOD) ||
                  hit(paddr, `OFS_TS_COUNT);

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic dlEnable_q;
   logic ocfEnable_q;
   logic [31:0] linkWord_q;
   logic [7:0] tsPeriod_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlEnable_q <= 1'b0;
         ocfEnable_q <= 1'b0;
      end else if (wrEn && hit(paddr, `OFS_DL_CTRL)) begin
         dlEnable_q <= pwdata[`BIT_DL_ENABLE];
         ocfEnable_q <= pwdata[`BIT_OCF_ENABLE];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         linkWord_q <= `ZERO32;
      end else if (wrEn && hit(paddr, `OFS_LINK_WORD)) begin
         linkWord_q <= pwdata; // R19
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tsPeriod_q <= `TS_OFF;
      end else if (wrEn && hit(paddr, `OFS_TS_PERIOD)) begin
         tsPeriod_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txGo <= 1'b0;
         ocfInsert <= 1'b0;
         linkWord <= `ZERO32;
      end else begin
         txGo <= dlEnable_q; // R16
         ocfInsert <= ocfEnable_q; // R20
         linkWord <= linkWord_q;
      end
   end

   // ------------------------------------------------------------
   // Frame control, write-only pulses
   // ------------------------------------------------------------
   logic fcWrite;
   assign fcWrite = wrEn && hit(paddr, `OFS_FRAME_CTRL);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxBufferReset <= 1'b0;
         rxFrameRead <= 1'b0;
      end else begin
         rxBufferReset <= fcWrite && pwdata[`BIT_FC_RESET]; // R14
         rxFrameRead <= fcWrite && pwdata[`BIT_FC_READ]; // R13
      end
   end

   // ------------------------------------------------------------
   // Downlink state
   // ------------------------------------------------------------
   tmtc_status_pkg::dl_state_t dlState_q;
   logic dlFault_q;
   logic dlRefused_q;
   logic [7:0] descAddr_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlState_q <= tmtc_status_pkg::DL_IDLE;
      end else begin
         case (dlState_q)
            tmtc_status_pkg::DL_IDLE: begin
               if (txStart && dlEnable_q) begin
                  dlState_q <= tmtc_status_pkg::DL_SEND; // R16
               end
            end
            tmtc_status_pkg::DL_SEND: begin
               if (txFifoError) begin
                  dlState_q <= tmtc_status_pkg::DL_FAULT;
               end else if (txDone || !dlEnable_q) begin
                  dlState_q <= tmtc_status_pkg::DL_IDLE;
               end
            end
            tmtc_status_pkg::DL_FAULT: begin
               dlState_q <= tmtc_status_pkg::DL_IDLE;
            end
            default: begin
               dlState_q <= tmtc_status_pkg::DL_IDLE;
            end
         endcase
      end
   end

   // Sticky fault, cleared by writing 1 to its bit; set wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlFault_q <= 1'b0;
      end else if (txFifoError) begin
         dlFault_q <= 1'b1; // R1
      end else if (wrEn && hit(paddr, `OFS_DL_STATUS) && pwdata[`BIT_DL_FAULT]) begin
         dlFault_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlRefused_q <= 1'b0;
      end else if (txStart && !dlEnable_q) begin
         dlRefused_q <= 1'b1; // R16
      end else if (wrEn && hit(paddr, `OFS_DL_STATUS) && pwdata[`BIT_DL_REFUSED]) begin
         dlRefused_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         descAddr_q <= 8'h00;
      end else if (txDone) begin
         descAddr_q <= txDescAddr; // R3
      end
   end

   // ------------------------------------------------------------
   // Timestamp period
   // ------------------------------------------------------------
   logic [7:0] tsCount_q;
   logic tsHit;
   assign tsHit = txFrameSent && (tsPeriod_q != `TS_OFF) && (tsCount_q + `CNT8_ONE >= tsPeriod_q);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tsCount_q <= 8'h00;
         timestampTake <= 1'b0;
      end else begin
         timestampTake <= tsHit; // R15
         if (tsPeriod_q == `TS_OFF || tsHit) begin
            tsCount_q <= 8'h00; // R15
         end else if (txFrameSent) begin
            tsCount_q <= tsCount_q + `CNT8_ONE;
         end
      end
   end

   // ------------------------------------------------------------
   // Uplink status
   // ------------------------------------------------------------
   logic [10:0] rxLength_q;
   logic [11:0] pulseLines_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxLength_q <= 11'h000;
      end else if (rxBufferReset) begin
         rxLength_q <= 11'h000;
      end else begin
         rxLength_q <= (rxLength > `LEN_MAX) ? `LEN_MAX : rxLength; // R6
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulseLines_q <= 12'h000;
      end else if (pulseAccept) begin
         pulseLines_q <= pulseLines; // R7
      end
   end

   // ------------------------------------------------------------
   // Event counters
   // ------------------------------------------------------------
   localparam int NCNT = 6;
   logic [NCNT-1:0] cntInc;
   logic [7:0] cntVal [NCNT];
   logic [3:0] acceptCnt;
   assign cntInc = {pulseReject, rxRejected, rxOverflow, rxCrcError, rxFrame, txCrcError};

   // Six event counters, each wraps at eight bits
   generate
      for (genvar i = 0; i < NCNT; i++) begin : g_cnt
         wrap_counter #(.WIDTH(8)) u_cnt (
            .clk(clk),
            .sys_rst(sys_rst),
            .clear(1'b0),
            .inc(cntInc[i]), // R4 R5 R9 R10 R11 R12
            .count(cntVal[i])
         );
      end
   endgenerate

   wrap_counter #(.WIDTH(4)) u_accept (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(1'b0),
      .inc(pulseAccept), // R8
      .count(acceptCnt)
   );

   // ------------------------------------------------------------
   // Read mux and APB answer
   // ------------------------------------------------------------
   logic [31:0] rdData;
   always_comb begin
      rdData = `ZERO32;
      if (hit(paddr, `OFS_DL_CTRL)) begin
         rdData = {30'h0, ocfEnable_q, dlEnable_q};
      end else if (hit(paddr, `OFS_DL_STATUS)) begin
         rdData = {21'h0, dlRefused_q, dlState_q == tmtc_status_pkg::DL_SEND, dlFault_q, descAddr_q}; // R1 R2
      end else if (hit(paddr, `OFS_DL_ERRCNT)) begin
         rdData = {24'h0, cntVal[0]};
      end else if (hit(paddr, `OFS_UL_STATUS)) begin
         rdData = {acceptCnt, pulseLines_q, 5'h00, rxLength_q};
      end else if (hit(paddr, `OFS_UL_ERRCNT)) begin
         rdData = {cntVal[5], cntVal[4], cntVal[3], cntVal[2]};
      end else if (hit(paddr, `OFS_FRAME_CTRL)) begin
         rdData = `ZERO32; // R21
      end else if (hit(paddr, `OFS_LINK_WORD)) begin
         rdData = linkWord_q; // R19
      end else if (hit(paddr, `OFS_TS_PERIOD)) begin
         rdData = {24'h0, tsPeriod_q};
      end else if (hit(paddr, `OFS_TS_COUNT)) begin
         rdData = {24'h0, cntVal[1]};
      end
   end

   // Answer in the first access cycle; unknown address gives pslverr
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= `ZERO32;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         if (rdEn) begin
            prdata <= rdData;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_fault_sticky: assert property (@(posedge clk) disable iff (sys_rst) // R1
      txFifoError |=> dlFault_q) else $error("fault flag not set");
   a_active_flag: assert property (@(posedge clk) disable iff (sys_rst) // R2
      (dlState_q == tmtc_status_pkg::DL_IDLE && txStart && dlEnable_q) |=> dlState_q == tmtc_status_pkg::DL_SEND)
      else $error("transfer not active");
   a_refuse_disabled: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (dlState_q == tmtc_status_pkg::DL_IDLE && !dlEnable_q) |=> dlState_q != tmtc_status_pkg::DL_SEND)
      else $error("sent while disabled");
   a_desc_capture: assert property (@(posedge clk) disable iff (sys_rst) // R3
      txDone |=> descAddr_q == $past(txDescAddr)) else $error("descriptor address wrong");
   a_crc_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R4
      (txCrcError && cntVal[0] == 8'hff) |=> cntVal[0] == 8'h00) else $error("crc count no wrap");
   a_frame_count: assert property (@(posedge clk) disable iff (sys_rst) // R5
      rxFrame |=> cntVal[1] == $past(cntVal[1]) + `CNT8_ONE) else $error("frame count wrong");
   a_len_limit: assert property (@(posedge clk) disable iff (sys_rst) // R6
      rxLength_q <= `LEN_MAX) else $error("length above limit");
   a_accept_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R8
      (pulseAccept && acceptCnt == 4'hf) |=> acceptCnt == 4'h0) else $error("accept count no wrap");
   a_frame_read: assert property (@(posedge clk) disable iff (sys_rst) // R13
      (fcWrite && pwdata[`BIT_FC_READ]) |=> rxFrameRead ##1 !rxFrameRead) else $error("read pulse wrong");
   a_buf_reset: assert property (@(posedge clk) disable iff (sys_rst) // R14
      rxBufferReset |-> $past(fcWrite) && $past(pwdata[`BIT_FC_RESET])) else $error("spurious buffer reset");
   a_ts_off: assert property (@(posedge clk) disable iff (sys_rst) // R15
      (tsPeriod_q == `TS_OFF) |=> !timestampTake) else $error("timestamp while off");
   a_link_word: assert property (@(posedge clk) disable iff (sys_rst) // R19
      (wrEn && hit(paddr, `OFS_LINK_WORD)) |=> ##1 linkWord == $past(pwdata, 2)) else $error("link word lost");
   a_ocf_gate: assert property (@(posedge clk) disable iff (sys_rst) // R20
      ocfInsert == $past(ocfEnable_q)) else $error("insert mismatch");

   c_transfer: cover property (@(posedge clk) disable iff (sys_rst)
      dlState_q == tmtc_status_pkg::DL_SEND ##[1:20] txDone);
   c_fault: cover property (@(posedge clk) disable iff (sys_rst) txFifoError && dlFault_q);
   c_timestamp: cover property (@(posedge clk) disable iff (sys_rst) timestampTake);
   c_frame_ack: cover property (@(posedge clk) disable iff (sys_rst) rxFrameRead);
endmodule

// *** testbench/radio_model.sv ***
// Far-side radio and data-path event source for the status block
`timescale 1ns/1ps
module radio_model (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Async reset, high
   output logic txStart, // Submission pulse
   output logic txFrameSent, // Frame sent pulse
   output logic txDone, // DMA finished pulse
   output logic [7:0] txDescAddr, // Descriptor address LSB
   output logic txFifoError, // FIFO error pulse
   output logic txCrcError, // Downlink CRC error pulse
   output logic rxFrame, // Frame received pulse
   output logic [10:0] rxLength, // Read buffer length
   output logic rxOverflow, // Frame lost pulse
   output logic rxRejected, // Telecommand rejected pulse
   output logic rxCrcError, // Uplink CRC error pulse
   output logic pulseAccept, // Pulse command accepted
   output logic pulseReject, // Pulse command rejected
   output logic [11:0] pulseLines // Lines of accepted command
);
   logic [10:0] evQ = 11'h000;
   assign {pulseReject, pulseAccept, rxCrcError, rxRejected, rxOverflow, rxFrame} = evQ[10:5];
   assign {txCrcError, txFifoError, txDone, txFrameSent, txStart} = evQ[4:0];
   initial begin
      txDescAddr = 8'h00;
      rxLength = 11'h000;
      pulseLines = 12'h000;
   end
   // One-cycle events; qualifiers turn over afterwards so no stale value lingers
   task automatic fire(input logic [10:0] ev, input logic [7:0] desc, input logic [11:0] lines);
      @(posedge clk);
      evQ <= sys_rst ? 11'h000 : ev;
      txDescAddr <= desc;
      pulseLines <= lines;
      @(posedge clk);
      evQ <= 11'h000;
      txDescAddr <= ~desc;
      pulseLines <= ~lines;
   endtask
   task automatic set_length(input logic [10:0] len);
      @(posedge clk);
      rxLength <= len;
   endtask
endmodule

// *** testbench/ccsds_tm_tc_status_ctrl_tb_top.sv ***
// Self-checking bench of the TM/TC status and control block
`timescale 1ns/1ps
`include "tmtc_status_cfg.svh"
module ccsds_tm_tc_status_ctrl_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, linkWord;
   logic pready, pslverr, txGo, ocfInsert, timestampTake, rxBufferReset, rxFrameRead;
   logic txStart, txFrameSent, txDone, txFifoError, txCrcError, rxFrame, rxOverflow;
   logic rxRejected, rxCrcError, pulseAccept, pulseReject;
   logic [7:0] txDescAddr;
   logic [10:0] rxLength;
   logic [11:0] pulseLines;
   int fails = 0;
   int nCompared = 0;
   int cycles = 0;
   int nRead = 0;
   int nReset = 0;
   int nStamp = 0;
   integer seed = 32'hf8b750a3;
   logic [11:0] regs [9] = '{`OFS_DL_CTRL, `OFS_DL_STATUS, `OFS_DL_ERRCNT, `OFS_UL_STATUS, `OFS_UL_ERRCNT,
      `OFS_FRAME_CTRL, `OFS_LINK_WORD, `OFS_TS_PERIOD, `OFS_TS_COUNT};

   always #50 clk = ~clk;

   radio_model radio (.clk(clk), .sys_rst(sys_rst), .txStart(txStart), .txFrameSent(txFrameSent),
      .txDone(txDone), .txDescAddr(txDescAddr), .txFifoError(txFifoError), .txCrcError(txCrcError),
      .rxFrame(rxFrame), .rxLength(rxLength), .rxOverflow(rxOverflow), .rxRejected(rxRejected),
      .rxCrcError(rxCrcError), .pulseAccept(pulseAccept), .pulseReject(pulseReject), .pulseLines(pulseLines));

   tmtc_status_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txStart(txStart),
      .txFrameSent(txFrameSent), .txDone(txDone), .txDescAddr(txDescAddr), .txFifoError(txFifoError),
      .txCrcError(txCrcError), .rxFrame(rxFrame), .rxLength(rxLength), .rxOverflow(rxOverflow),
      .rxRejected(rxRejected), .rxCrcError(rxCrcError), .pulseAccept(pulseAccept), .pulseReject(pulseReject),
      .pulseLines(pulseLines), .txGo(txGo), .ocfInsert(ocfInsert), .linkWord(linkWord),
      .timestampTake(timestampTake), .rxBufferReset(rxBufferReset), .rxFrameRead(rxFrameRead));

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Monitors and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (rxFrameRead === 1'b1) nRead++;
      if (rxBufferReset === 1'b1) nReset++;
      if (timestampTake === 1'b1) nStamp++;
      if (cycles == 30000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // ------------------------------------------------------------
   // APB master
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) check(32'h0000_0001, 32'h0000_0000);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, exp);
      check({31'h0, e}, 32'h0000_0000);
   endtask

   task automatic all_zero();
      for (int i = 0; i < 9; i++) rd_chk(regs[i], `ZERO32);
      check({27'h0, txGo, ocfInsert, timestampTake, rxBufferReset, rxFrameRead}, `ZERO32);
   endtask

   function automatic logic [10:0] exp_len(input logic [10:0] v);
      return (v > `LEN_MAX) ? `LEN_MAX : v;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r, lw, wv [5];
      logic e;
      logic [7:0] desc, p;
      logic [7:0] cnt [11];
      logic [3:0] acc;
      logic [10:0] ev, lv [4];
      logic [11:0] ln, lines;
      int r0, s0, t0, f;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      all_zero();
      apb(1'b0, 12'h024, 32'h0000_0000, r, e);
      check(r, `ZERO32);
      check({31'h0, e}, 32'h0000_0001);
      $display("reset test done");
      radio.fire(11'h001, 8'h00, 12'h000);
      rd_chk(`OFS_DL_STATUS, 32'h0000_0400);
      wr(`OFS_DL_STATUS, 32'h0000_0400);
      rd_chk(`OFS_DL_STATUS, `ZERO32);
      wr(`OFS_DL_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      check({31'h0, txGo}, 32'h0000_0001);
      radio.fire(11'h001, 8'h00, 12'h000);
      rd_chk(`OFS_DL_STATUS, 32'h0000_0200);
      desc = 8'($random(seed));
      radio.fire(11'h004, desc, 12'h000);
      rd_chk(`OFS_DL_STATUS, {24'h0, desc});
      radio.fire(11'h001, 8'h00, 12'h000);
      radio.fire(11'h008, 8'h00, 12'h000);
      rd_chk(`OFS_DL_STATUS, {23'h0, 1'b1, desc});
      wr(`OFS_DL_STATUS, 32'h0000_0100);
      rd_chk(`OFS_DL_STATUS, {24'h0, desc});
      lw = $random(seed);
      wr(`OFS_LINK_WORD, lw);
      rd_chk(`OFS_LINK_WORD, lw);
      check(linkWord, lw);
      wr(`OFS_DL_CTRL, 32'h0000_0003);
      repeat (3) @(posedge clk);
      check({30'h0, txGo, ocfInsert}, 32'h0000_0003);
      rd_chk(`OFS_DL_CTRL, 32'h0000_0003);
      wr(`OFS_DL_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      check({30'h0, txGo, ocfInsert}, 32'h0000_0002);
      radio.fire(11'h001, 8'h00, 12'h000);
      wr(`OFS_DL_CTRL, `ZERO32);
      rd_chk(`OFS_DL_STATUS, {24'h0, desc});
      $display("downlink test done");
      wv = '{32'h0000_0000, 32'h0000_0002, 32'hffff_fffc, 32'h0000_0001, 32'h0000_0003};
      for (int i = 0; i < 5; i++) begin
         r0 = nRead;
         s0 = nReset;
         wr(`OFS_FRAME_CTRL, wv[i]);
         repeat (3) @(posedge clk);
         check(32'(nRead - r0), {31'h0, wv[i][1]});
         check(32'(nReset - s0), {31'h0, wv[i][0]});
      end
      rd_chk(`OFS_FRAME_CTRL, `ZERO32);
      $display("frame control test done");
      for (int b = 0; b < 11; b++) cnt[b] = 8'h00;
      acc = 4'h0;
      lines = 12'h000;
      for (int i = 0; i < 600; i++) begin
         ev = 11'($random(seed)) & 11'h7f0;
         ln = 12'($random(seed));
         radio.fire(ev, 8'h00, ln);
         for (int b = 4; b < 11; b++) if (ev[b]) cnt[b] = cnt[b] + `CNT8_ONE;
         if (ev[9]) begin
            acc = acc + `CNT4_ONE;
            lines = ln;
         end
      end
      rd_chk(`OFS_DL_ERRCNT, {24'h0, cnt[4]});
      rd_chk(`OFS_UL_ERRCNT, {cnt[10], cnt[7], cnt[6], cnt[8]});
      rd_chk(`OFS_TS_COUNT, {24'h0, cnt[5]});
      lv = '{11'h000, `LEN_MAX, 11'h7ff, 11'($random(seed) % 1025)};
      for (int i = 0; i < 4; i++) begin
         radio.set_length(lv[i]);
         rd_chk(`OFS_UL_STATUS, {acc, lines, 5'h00, exp_len(lv[i])});
      end
      radio.set_length(11'h000);
      $display("counter test done");
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 8'h01 : (i == 1) ? 8'h03 : (i == 2) ? 8'hff : `TS_OFF;
         f = (i == 0) ? 5 : (i == 1) ? 9 : (i == 2) ? 255 : 6;
         wr(`OFS_TS_PERIOD, {24'h0, p});
         rd_chk(`OFS_TS_PERIOD, {24'h0, p});
         t0 = nStamp;
         repeat (f) radio.fire(11'h002, 8'h00, 12'h000);
         repeat (3) @(posedge clk);
         check(32'(nStamp - t0), (p == `TS_OFF) ? 32'h0 : 32'(f / p));
      end
      $display("timestamp test done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      all_zero();
      $display("second reset test done");
      print_verdict();
   end
endmodule
